// ### brkb_cfg.svh
// offsets, field positions, reset values for the channel b break matcher
`ifndef BRKB_CFG_SVH
`define BRKB_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define BRKB_OFF_ADDR 8'h00
`define BRKB_OFF_AMASK 8'h04
`define BRKB_OFF_DATA 8'h08
`define BRKB_OFF_DMASK 8'h0C
`define BRKB_OFF_QUAL 8'h10
`define BRKB_OFF_CTRL 8'h14
`define BRKB_OFF_ASID 8'h18
`define BRKB_OFF_IRQ_STAT 8'h1C
`define BRKB_OFF_IRQ_MASK 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BRKB_QUAL_MASTER_HI 7
`define BRKB_QUAL_MASTER_LO 6
`define BRKB_QUAL_ACCESS_HI 5
`define BRKB_QUAL_ACCESS_LO 4
`define BRKB_QUAL_DIR_HI 3
`define BRKB_QUAL_DIR_LO 2
`define BRKB_QUAL_SIZE_HI 1
`define BRKB_QUAL_SIZE_LO 0
`define BRKB_CTRL_ASID_DIS 20
`define BRKB_CTRL_CPU_FLAG 14
`define BRKB_CTRL_DMA_FLAG 12
`define BRKB_CTRL_DATA_EN 3
`define BRKB_IRQ_CPU 0
`define BRKB_IRQ_DMA 1

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define BRKB_RST_WORD 32'h0000_0000
`define BRKB_RST_QUAL 8'h00
`define BRKB_RST_ASID 8'h00
`define BRKB_RST_IRQ 2'h0
`define BRKB_SEL_NONE 2'h0
`define BRKB_SEL_LO 2'h1
`define BRKB_SEL_HI 2'h2
`define BRKB_SZ_BYTE 2'h1
`define BRKB_SZ_WORD 2'h2
`define BRKB_SZ_LONG 2'h3

`endif

// ### brkb_pkg.sv
// types shared by the channel b break matcher
package brkb_pkg;

    // one observed bus cycle; size coded 01 byte, 10 word, 11 long
    typedef struct packed {
        logic valid;
        logic is_dma;
        logic is_fetch;
        logic is_write;
        logic [1:0] size;
        logic [7:0] asid;
        logic [31:0] addr;
        logic [31:0] data;
    } brkb_bus_t;

    // software-set compare settings
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] amask;
        logic [31:0] bdata;
        logic [31:0] dmask;
        logic [7:0] qual;
        logic [7:0] asid;
        logic asid_dis;
        logic data_en;
    } brkb_cfg_t;

endpackage

// ### brkb_cmp.sv
// combinational channel b condition compare
`timescale 1ns/1ps
`include "brkb_cfg.svh"

module brkb_cmp import brkb_pkg::*; (
    input wire brkb_cfg_t cfg,
    input wire brkb_bus_t bus,
    output logic hit_cpu,
    output logic hit_dma
);

    // equal on every bit whose mask bit is 0
    function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b,
                                       input logic [31:0] m);
        masked_eq = ((a ^ b) & ~m) == 32'h0000_0000;
    endfunction

    // two-bit selector: 00 never, 01 low case, 10 high case, 11 either
    function automatic logic sel_ok(input logic [1:0] sel, input logic is_hi);
        sel_ok = is_hi ? sel[1] : sel[0];
    endfunction

    logic [1:0] master;
    logic [1:0] access;
    logic [1:0] dir;
    logic [1:0] size;
    logic addr_ok;
    logic data_ok;
    logic asid_ok;
    logic qual_ok;
    logic [7:0] brk_byte;
    logic [7:0] msk_byte;

    // ----------------------------------------------------------------
    // condition terms
    // ----------------------------------------------------------------
    always_comb begin
        master = cfg.qual[`BRKB_QUAL_MASTER_HI:`BRKB_QUAL_MASTER_LO];
        access = cfg.qual[`BRKB_QUAL_ACCESS_HI:`BRKB_QUAL_ACCESS_LO];
        dir = cfg.qual[`BRKB_QUAL_DIR_HI:`BRKB_QUAL_DIR_LO];
        size = cfg.qual[`BRKB_QUAL_SIZE_HI:`BRKB_QUAL_SIZE_LO];
        addr_ok = masked_eq(bus.addr, cfg.addr, cfg.amask);
        // byte compare lane follows address parity
        brk_byte = bus.addr[0] ? cfg.bdata[7:0] : cfg.bdata[15:8];
        msk_byte = bus.addr[0] ? cfg.dmask[7:0] : cfg.dmask[15:8];
        data_ok = 1'b1;
        if (cfg.data_en) begin
            if (bus.size == `BRKB_SZ_BYTE) begin
                data_ok = masked_eq({24'h00_0000, bus.data[7:0]}, {24'h00_0000, brk_byte},
                                    {24'hFF_FFFF, msk_byte});
            end else if (bus.size == `BRKB_SZ_WORD) begin
                data_ok = masked_eq({16'h0000, bus.data[15:0]}, {16'h0000, cfg.bdata[15:0]},
                                    {16'hFFFF, cfg.dmask[15:0]});
            end else begin
                data_ok = masked_eq(bus.data, cfg.bdata, cfg.dmask);
            end
        end
        asid_ok = cfg.asid_dis || (bus.asid == cfg.asid);
        // a 00 access or direction selector never matches; a 00 size selector means no size comparison
        qual_ok = sel_ok(access, ~bus.is_fetch)
            && sel_ok(dir, bus.is_write)
            && (size == `BRKB_SEL_NONE || size == bus.size);
    end

    // ----------------------------------------------------------------
    // per-master hits, all terms in the same cycle
    // ----------------------------------------------------------------
    always_comb begin
        hit_cpu = bus.valid && !bus.is_dma && master[0]
            && addr_ok && data_ok && asid_ok && qual_ok;
        hit_dma = bus.valid && bus.is_dma && (master == `BRKB_SEL_HI)
            && addr_ok && data_ok && asid_ok && qual_ok;
    end

endmodule

// ### brkb_top.sv
// channel b break matcher: registers, flags, interrupt
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "brkb_cfg.svh"

module brkb_top import brkb_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire brkb_bus_t bus_i,
    output logic match_cpu,
    output logic match_dma,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    brkb_cfg_t cfg_r;
    brkb_cfg_t cfg_nxt;
    logic cpu_flag_r;
    logic cpu_flag_nxt;
    logic dma_flag_r;
    logic dma_flag_nxt;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_stat_nxt;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_mask_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic match_cpu_r;
    logic match_dma_r;
    logic hit_cpu;
    logic hit_dma;
    logic wr_ctrl;
    logic [31:0] ctrl_view;

    // ----------------------------------------------------------------
    // compare
    // ----------------------------------------------------------------
    brkb_cmp u_cmp (
        .cfg(cfg_r),
        .bus(bus_i),
        .hit_cpu(hit_cpu),
        .hit_dma(hit_dma)
    );

    // control word as software sees it
    always_comb begin
        ctrl_view = `BRKB_RST_WORD;
        ctrl_view[`BRKB_CTRL_ASID_DIS] = cfg_r.asid_dis;
        ctrl_view[`BRKB_CTRL_CPU_FLAG] = cpu_flag_r;
        ctrl_view[`BRKB_CTRL_DMA_FLAG] = dma_flag_r;
        ctrl_view[`BRKB_CTRL_DATA_EN] = cfg_r.data_en;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_comb begin
        cfg_nxt = cfg_r;
        irq_mask_nxt = irq_mask_r;
        wr_ctrl = reg_wr && (reg_addr == `BRKB_OFF_CTRL);
        if (reg_wr) begin
            if (reg_addr == `BRKB_OFF_ADDR) begin
                cfg_nxt.addr = reg_wdata;
            end else if (reg_addr == `BRKB_OFF_AMASK) begin
                cfg_nxt.amask = reg_wdata;
            end else if (reg_addr == `BRKB_OFF_DATA) begin
                cfg_nxt.bdata = reg_wdata;
            end else if (reg_addr == `BRKB_OFF_DMASK) begin
                cfg_nxt.dmask = reg_wdata;
            end else if (reg_addr == `BRKB_OFF_QUAL) begin
                cfg_nxt.qual = reg_wdata[7:0]; // upper 24 bits not stored
            end else if (reg_addr == `BRKB_OFF_CTRL) begin
                cfg_nxt.asid_dis = reg_wdata[`BRKB_CTRL_ASID_DIS];
                cfg_nxt.data_en = reg_wdata[`BRKB_CTRL_DATA_EN];
            end else if (reg_addr == `BRKB_OFF_ASID) begin
                cfg_nxt.asid = reg_wdata[7:0];
            end else if (reg_addr == `BRKB_OFF_IRQ_MASK) begin
                irq_mask_nxt = reg_wdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky flags: a hit in the clearing cycle wins over the clear
    // ----------------------------------------------------------------
    always_comb begin
        cpu_flag_nxt = cpu_flag_r;
        dma_flag_nxt = dma_flag_r;
        if (wr_ctrl && !reg_wdata[`BRKB_CTRL_CPU_FLAG]) begin
            cpu_flag_nxt = 1'b0;
        end
        if (wr_ctrl && !reg_wdata[`BRKB_CTRL_DMA_FLAG]) begin
            dma_flag_nxt = 1'b0;
        end
        if (hit_cpu) begin
            cpu_flag_nxt = 1'b1;
        end
        if (hit_dma) begin
            dma_flag_nxt = 1'b1;
        end
    end

    // interrupt status: read clears, new events still land
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (reg_rd && reg_addr == `BRKB_OFF_IRQ_STAT) begin
            irq_stat_nxt = `BRKB_RST_IRQ;
        end
        irq_stat_nxt[`BRKB_IRQ_CPU] = irq_stat_nxt[`BRKB_IRQ_CPU] | hit_cpu;
        irq_stat_nxt[`BRKB_IRQ_DMA] = irq_stat_nxt[`BRKB_IRQ_DMA] | hit_dma;
    end

    // ----------------------------------------------------------------
    // read path, data valid the cycle after the strobe
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = `BRKB_RST_WORD;
        if (reg_rd) begin
            if (reg_addr == `BRKB_OFF_ADDR) begin
                rdata_nxt = cfg_r.addr;
            end else if (reg_addr == `BRKB_OFF_AMASK) begin
                rdata_nxt = cfg_r.amask;
            end else if (reg_addr == `BRKB_OFF_DATA) begin
                rdata_nxt = cfg_r.bdata;
            end else if (reg_addr == `BRKB_OFF_DMASK) begin
                rdata_nxt = cfg_r.dmask;
            end else if (reg_addr == `BRKB_OFF_QUAL) begin
                rdata_nxt = {24'h00_0000, cfg_r.qual};
            end else if (reg_addr == `BRKB_OFF_CTRL) begin
                rdata_nxt = ctrl_view;
            end else if (reg_addr == `BRKB_OFF_ASID) begin
                rdata_nxt = {24'h00_0000, cfg_r.asid};
            end else if (reg_addr == `BRKB_OFF_IRQ_STAT) begin
                rdata_nxt = {30'h0, irq_stat_r};
            end else if (reg_addr == `BRKB_OFF_IRQ_MASK) begin
                rdata_nxt = {30'h0, irq_mask_r};
            end
        end
    end

    // ----------------------------------------------------------------
    // registers; zero compare settings mean master select 00, no match
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_r <= '0;
            cpu_flag_r <= 1'b0;
            dma_flag_r <= 1'b0;
            irq_stat_r <= `BRKB_RST_IRQ;
            irq_mask_r <= `BRKB_RST_IRQ;
            rdata_r <= `BRKB_RST_WORD;
            match_cpu_r <= 1'b0;
            match_dma_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            cpu_flag_r <= cpu_flag_nxt;
            dma_flag_r <= dma_flag_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            rdata_r <= rdata_nxt;
            match_cpu_r <= hit_cpu;
            match_dma_r <= hit_dma;
        end
    end

    // outputs
    assign reg_rdata = rdata_r;
    assign match_cpu = match_cpu_r;
    assign match_dma = match_dma_r;
    assign irq = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_addr_miss;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && (((bus_i.addr ^ cfg_r.addr) & ~cfg_r.amask) != 32'h0000_0000)
            |=> !match_cpu && !match_dma;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("match despite address miss");

    property p_mask_hit;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && !bus_i.is_dma && cfg_r.amask == 32'hFFFF_FFFF && cfg_r.qual == 8'hFC
            && !cfg_r.data_en && cfg_r.asid_dis |=> match_cpu;
    endproperty
    a_mask_hit: assert property (p_mask_hit) else $error("fully masked cpu cycle missed");

    property p_long_data_miss;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && cfg_r.data_en && bus_i.size == `BRKB_SZ_LONG
            && (((bus_i.data ^ cfg_r.bdata) & ~cfg_r.dmask) != 32'h0000_0000)
            |=> !match_cpu && !match_dma;
    endproperty
    a_long_data_miss: assert property (p_long_data_miss) else $error("data miss matched");

    property p_byte_lane;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && cfg_r.data_en && bus_i.size == `BRKB_SZ_BYTE && !bus_i.addr[0]
            && (((bus_i.data[7:0] ^ cfg_r.bdata[15:8]) & ~cfg_r.dmask[15:8]) != 8'h00)
            |=> !match_cpu && !match_dma;
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("even byte lane wrong");

    property p_master;
        @(posedge clk) disable iff (!rst_n)
        (cfg_r.qual[7:6] == `BRKB_SEL_NONE |=> !match_cpu && !match_dma)
        and (cfg_r.qual[6] |=> !match_dma)
        and (cfg_r.qual[7:6] == `BRKB_SEL_HI |=> !match_cpu);
    endproperty
    a_master: assert property (p_master) else $error("bus master selector ignored");

    property p_access;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && !cfg_r.qual[bus_i.is_fetch ? 4 : 5] |=> !match_cpu && !match_dma;
    endproperty
    a_access: assert property (p_access) else $error("access type selector ignored");

    property p_dir;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && !cfg_r.qual[bus_i.is_write ? 3 : 2] |=> !match_cpu && !match_dma;
    endproperty
    a_dir: assert property (p_dir) else $error("direction selector ignored");

    property p_size;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && cfg_r.qual[1:0] != `BRKB_SEL_NONE && cfg_r.qual[1:0] != bus_i.size
            |=> !match_cpu && !match_dma;
    endproperty
    a_size: assert property (p_size) else $error("size selector ignored");

    property p_qual_read;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `BRKB_OFF_QUAL |=> reg_rdata[31:8] == 24'h00_0000
            && reg_rdata[7:0] == $past(cfg_r.qual);
    endproperty
    a_qual_read: assert property (p_qual_read) else $error("qualifier read wrong");

    property p_flag;
        @(posedge clk) disable iff (!rst_n)
        (match_cpu |-> cpu_flag_r)
        and (cpu_flag_r && !(wr_ctrl && !reg_wdata[`BRKB_CTRL_CPU_FLAG]) |=> cpu_flag_r);
    endproperty
    a_flag: assert property (p_flag) else $error("cpu match flag not sticky");

    property p_asid;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && !cfg_r.asid_dis && bus_i.asid != cfg_r.asid |=> !match_cpu && !match_dma;
    endproperty
    a_asid: assert property (p_asid) else $error("asid mismatch matched");

    property p_reset;
        @(posedge clk)
        !rst_n |=> cfg_r == '0 && !match_cpu && !match_dma && !irq;
    endproperty
    a_reset: assert property (p_reset) else $error("reset left compare state");

    property p_odd_lane;
        @(posedge clk) disable iff (!rst_n)
        bus_i.valid && cfg_r.data_en && bus_i.size == `BRKB_SZ_BYTE && bus_i.addr[0]
            && (((bus_i.data[7:0] ^ cfg_r.bdata[7:0]) & ~cfg_r.dmask[7:0]) != 8'h00)
            |=> !match_cpu && !match_dma;
    endproperty
    a_odd_lane: assert property (p_odd_lane) else $error("odd byte lane wrong");

    // a clear with no hit in the same cycle must take effect
    property p_flag_clear;
        @(posedge clk) disable iff (!rst_n)
        wr_ctrl && !reg_wdata[`BRKB_CTRL_CPU_FLAG] && !hit_cpu |=> !cpu_flag_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("cpu flag not cleared");

    property p_idle_bus;
        @(posedge clk) disable iff (!rst_n)
        !bus_i.valid |=> !match_cpu && !match_dma;
    endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("match without cycle");

    property p_master_kind;
        @(posedge clk) disable iff (!rst_n)
        (bus_i.valid && bus_i.is_dma |=> !match_cpu)
        and (bus_i.valid && !bus_i.is_dma |=> !match_dma);
    endproperty
    a_master_kind: assert property (p_master_kind) else $error("wrong master");

endmodule

// ### brkb_bus_model.sv
// bus traffic model: cpu and dma cycles seen by the channel b matcher
`timescale 1ns/1ps

module brkb_bus_model import brkb_pkg::*; (
    input wire logic clk,
    input wire brkb_bus_t req,
    output brkb_bus_t bus_cyc
);
    brkb_bus_t bus_r = '0;
    brkb_bus_t idle_v;

    // ----------------------------------------------------------------
    // cycle launch
    // ----------------------------------------------------------------
    // a cycle lasts one clock; between cycles every line but valid toggles so that
    // a stale address or data word can never pass for a fresh cycle
    always @(posedge clk) begin
        idle_v = ~bus_r;
        idle_v.valid = 1'b0;
        bus_r <= req.valid ? req : idle_v;
    end

    // byte operands travel on the low lane, as the core drives them
    assign bus_cyc = bus_r;
endmodule

// ### break_channel_b_match_bench.sv
// self-checking bench for the channel b break matcher
`timescale 1ns/1ps
`include "brkb_cfg.svh"

module break_channel_b_match_bench import brkb_pkg::*; ;
    localparam logic [31:0] ba = 32'h8000_1000;
    localparam logic [31:0] zw = 32'h0000_0000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    brkb_bus_t req = '0;
    brkb_bus_t bus_cyc;
    logic match_cpu;
    logic match_dma;
    logic irq;
    logic [1:0] hits;
    logic [31:0] rdv;
    int error_cnt = 0;
    int total_checks = 0;

    brkb_bus_model core_bus (.clk(clk), .req(req), .bus_cyc(bus_cyc));

    brkb_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_i(bus_cyc),
        .match_cpu(match_cpu), .match_dma(match_dma), .irq(irq));

    // ----------------------------------------------------------------
    // clock and helpers
    // ----------------------------------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask

    // one watched cycle; the match pulse is taken one clock after it
    task automatic cyc(input logic dma, input logic fetch, input logic wrt,
            input logic [1:0] sz, input logic [7:0] asid, input logic [31:0] a,
            input logic [31:0] d);
        @(posedge clk);
        req <= {1'b1, dma, fetch, wrt, sz, asid, a, d};
        @(posedge clk);
        req.valid <= 1'b0;
        @(posedge clk);
        #1;
        hits = {match_cpu, match_dma};
    endtask

    // expected {cpu, dma} hit for a qualifier, address and asid agreeing
    function automatic logic [1:0] exp_hit(input logic [7:0] q, input logic dma,
            input logic fetch, input logic wrt, input logic [1:0] sz);
        logic ok;
        ok = (q[7:6] != 2'h0) && (q[5:4] != 2'h0) && (q[3:2] != 2'h0);
        ok = ok && (dma ? (q[7:6] == 2'h2) : q[6]);
        ok = ok && (fetch ? q[4] : q[5]);
        ok = ok && (wrt ? q[3] : q[2]);
        ok = ok && ((q[1:0] == 2'h0) || (q[1:0] == sz));
        return {ok && !dma, ok && dma};
    endfunction

    // hang guard: the full run needs well under this many clocks
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [1:0] sz_v;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // every register comes up zero and nothing matches
        for (int i = 0; i < 9; i++) begin
            rd(8'(i * 4));
            chk(rdv, zw);
        end
        cyc(1'b0, 1'b0, 1'b0, 2'h3, 8'h00, zw, zw);
        chk(32'(hits), zw);
        // read/write words, reserved qualifier bits, unmapped place
        for (int i = 0; i < 4; i++) begin
            wr(8'(i * 4), 32'h1357_9BDF ^ 32'(i));
            rd(8'(i * 4));
            chk(rdv, 32'h1357_9BDF ^ 32'(i));
        end
        wr(`BRKB_OFF_QUAL, 32'hFFFF_FFFF);
        rd(`BRKB_OFF_QUAL);
        chk(rdv, 32'h0000_00FF);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40);
        chk(rdv, zw);
        // every qualifier code against every kind of cycle, asid skipped
        wr(`BRKB_OFF_ADDR, ba);
        wr(`BRKB_OFF_AMASK, zw);
        wr(`BRKB_OFF_DMASK, zw);
        wr(`BRKB_OFF_CTRL, 32'h0010_0000);
        for (int q = 0; q < 256; q++) begin
            wr(`BRKB_OFF_QUAL, 32'(q));
            for (int k = 0; k < 24; k++) begin
                sz_v = 2'(k / 8 + 1);
                cyc(k[0], k[1], k[2], sz_v, 8'h00, ba, zw);
                chk(32'(hits), 32'(exp_hit(8'(q), k[0], k[1], k[2], sz_v)));
            end
        end
        // address mask and asid
        wr(`BRKB_OFF_QUAL, 32'h0000_007C);
        wr(`BRKB_OFF_AMASK, 32'h0000_000F);
        wr(`BRKB_OFF_ASID, 32'h0000_005A);
        wr(`BRKB_OFF_CTRL, zw);
        cyc(1'b0, 1'b0, 1'b0, 2'h3, 8'h5A, 32'h8000_100B, zw);
        chk(32'(hits), 32'h0000_0002);
        cyc(1'b0, 1'b0, 1'b0, 2'h3, 8'h5A, 32'h8000_1010, zw);
        chk(32'(hits), zw);
        cyc(1'b0, 1'b0, 1'b0, 2'h3, 8'h5A, 32'h0000_1000, zw);
        chk(32'(hits), zw);
        cyc(1'b0, 1'b0, 1'b0, 2'h3, 8'h5B, ba, zw);
        chk(32'(hits), zw);
        wr(`BRKB_OFF_CTRL, 32'h0010_0000);
        cyc(1'b0, 1'b0, 1'b0, 2'h3, 8'h5B, ba, zw);
        chk(32'(hits), 32'h0000_0002);
        // fully masked address: any cpu cycle matches
        wr(`BRKB_OFF_AMASK, 32'hFFFF_FFFF);
        wr(`BRKB_OFF_QUAL, 32'h0000_00FC);
        cyc(1'b0, 1'b1, 1'b0, 2'h2, 8'h33, 32'h0123_4567, zw);
        chk(32'(hits), 32'h0000_0002);
        // longword data compare with data mask
        wr(`BRKB_OFF_CTRL, 32'h0010_0008);
        wr(`BRKB_OFF_QUAL, 32'h0000_007F);
        wr(`BRKB_OFF_DATA, 32'hCAFE_F00D);
        cyc(1'b0, 1'b0, 1'b1, 2'h3, 8'h00, ba, 32'hCAFE_F00D);
        chk(32'(hits), 32'h0000_0002);
        cyc(1'b0, 1'b0, 1'b1, 2'h3, 8'h00, ba, 32'hCAFE_F00C);
        chk(32'(hits), zw);
        wr(`BRKB_OFF_DMASK, 32'h0000_0001);
        cyc(1'b0, 1'b0, 1'b1, 2'h3, 8'h00, ba, 32'hCAFE_F00C);
        chk(32'(hits), 32'h0000_0002);
        // byte compare lane follows the address parity
        wr(`BRKB_OFF_DMASK, zw);
        wr(`BRKB_OFF_QUAL, 32'h0000_007D);
        wr(`BRKB_OFF_DATA, 32'h0000_A53C);
        for (int i = 0; i < 4; i++) begin
            cyc(1'b0, 1'b0, 1'b0, 2'h1, 8'h00, ba | 32'(i[0]), {24'h1234_56, i[1] ? 8'h3C : 8'hA5});
            chk(32'(hits), 32'(i[0] ^ i[1] ? 2'h0 : 2'h2));
        end
        // sticky flag, status read-clear and interrupt masking
        wr(`BRKB_OFF_CTRL, 32'h0010_0008);
        rd(`BRKB_OFF_IRQ_STAT);
        rd(`BRKB_OFF_IRQ_STAT);
        chk(rdv, zw);
        wr(`BRKB_OFF_QUAL, 32'h0000_007F);
        wr(`BRKB_OFF_IRQ_MASK, 32'h0000_0001);
        chk(32'(irq), zw);
        // data compare is still on, so the long word must equal break data
        cyc(1'b0, 1'b0, 1'b0, 2'h3, 8'h00, ba, 32'h0000_A53C);
        chk(32'(irq), 32'h0000_0001);
        for (int i = 0; i < 3; i++) begin
            wr(`BRKB_OFF_CTRL, i == 2 ? 32'h0010_0008 : 32'h0010_4008);
            rd(`BRKB_OFF_CTRL);
            chk(rdv, i == 2 ? 32'h0010_0008 : 32'h0010_4008);
        end
        rd(`BRKB_OFF_IRQ_STAT);
        chk(rdv, 32'h0000_0001);
        chk(32'(irq), zw);
        wr(`BRKB_OFF_IRQ_MASK, zw);
        cyc(1'b0, 1'b0, 1'b0, 2'h3, 8'h00, ba, 32'h0000_A53C);
        chk(32'(irq), zw);
        rd(`BRKB_OFF_IRQ_STAT);
        chk(rdv, 32'h0000_0001);
        // dma cycle sets its own flag and status bit
        wr(`BRKB_OFF_QUAL, 32'h0000_00BF);
        cyc(1'b1, 1'b0, 1'b0, 2'h3, 8'h00, ba, 32'h0000_A53C);
        chk(32'(hits), 32'h0000_0001);
        rd(`BRKB_OFF_CTRL);
        chk(rdv, 32'h0010_5008);
        rd(`BRKB_OFF_IRQ_STAT);
        chk(rdv, 32'h0000_0002);
        close_out();
    end
endmodule
